// File: hpb_defs.svh
// Purpose: timing counts and field positions for the host bus master
// Assumes: 250 MHz mclk, 4 ns period
// Notes:   phase lengths are minimum host-side hold times in ps, rounded up to whole cycles
`ifndef HPB_DEFS_SVH
`define HPB_DEFS_SVH

`define HPB_CLK_PS        4000
`define HPB_SETUP_PS      8000
`define HPB_STROBE_PS     28000
`define HPB_TURN_PS       8000
`define HPB_SETUP_CYC     ((`HPB_SETUP_PS + `HPB_CLK_PS - 1) / `HPB_CLK_PS)
`define HPB_STROBE_CYC    ((`HPB_STROBE_PS + `HPB_CLK_PS - 1) / `HPB_CLK_PS)
`define HPB_TURN_CYC      ((`HPB_TURN_PS + `HPB_CLK_PS - 1) / `HPB_CLK_PS)
`define HPB_CNT_W         4
`define HPB_DATA_W        32
`define HPB_ADDR_LSB      2
`define HPB_ADDR_MSB      5
`define HPB_BIT3          3
`define HPB_BIT5          5
`define HPB_ONES32        32'hFFFF_FFFF
`define HPB_ZERO32        32'h0000_0000
`define HPB_ZERO_CNT      4'h0

`endif

// File: hpb_pkg.sv
// Purpose: types for the host bus master
// Assumes: nothing
// Notes:   state enum only
package hpb_pkg;
  typedef enum logic [2:0] {
    HPB_IDLE,
    HPB_ALE,
    HPB_SETUP,
    HPB_STROBE,
    HPB_TURN
  } hpb_state_t;
endpackage

// File: hpb_host.sv
// Purpose: host-side master for the device's 32-bit parallel host port
// Assumes: pins synchronous to mclk; device strap mirrored on mux_mode
// Notes:   one access at a time; request taken whenever valid in idle, ready not checked
//
// Contract
// - 32-bit data bus; host drives on writes, device drives on reads.
// - device drives data only while host holds output enable low.
// - write enable low means write, high means read.
// - strap 1: shared lines carry address bits, then data bits.
// - nonmux: address valid at chip select falling edge.
// - mux: address bit 2 pin serves as address latch strobe.
`timescale 1ns/1ps
`include "hpb_defs.svh"

module hpb_host
  import hpb_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // strap copy
  input  wire logic        mux_mode,
  // user request
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [31:0] req_addr,
  input  wire logic [31:0] req_wdata,
  output logic             req_ready,
  output logic             rsp_valid,
  output logic [31:0]      rsp_rdata,
  // device pins
  output logic             chip_sel_n,
  output logic             out_drv_en_n,
  output logic             write_en_n,
  output logic             dedicated_addr_bit2_or_strobe,
  output logic [5:3]       dedicated_addr_hi,
  output logic [31:0]      data_out,
  output logic [31:0]      data_oe_n,
  input  wire logic [31:0] data_in
);

  logic       rst_s1_r;
  logic       rst_s2_r;
  hpb_state_t state_r;
  logic [`HPB_CNT_W-1:0] cnt_r;
  logic       wr_r;
  logic [31:0] wdata_r;

  // reset release through two flops
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // access sequencer; counter times each phase
  always_ff @(posedge mclk or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
    begin
      state_r <= HPB_IDLE;
      cnt_r   <= `HPB_ZERO_CNT;
      wr_r    <= 1'b0;
      wdata_r <= `HPB_ZERO32;
    end
    else
    begin
      case (state_r)
        HPB_IDLE:
        begin
          if (req_valid)
          begin
            wr_r    <= req_write;
            wdata_r <= req_wdata;
            cnt_r   <= `HPB_CNT_W'(`HPB_SETUP_CYC - 1);
            state_r <= mux_mode ? HPB_ALE : HPB_SETUP;
          end
        end
        HPB_ALE:
        begin
          if (cnt_r == `HPB_ZERO_CNT)
          begin
            cnt_r   <= `HPB_CNT_W'(`HPB_SETUP_CYC - 1);
            state_r <= HPB_SETUP;
          end
          else
            cnt_r <= cnt_r - 1'b1;
        end
        HPB_SETUP:
        begin
          if (cnt_r == `HPB_ZERO_CNT)
          begin
            cnt_r   <= `HPB_CNT_W'(`HPB_STROBE_CYC - 1);
            state_r <= HPB_STROBE;
          end
          else
            cnt_r <= cnt_r - 1'b1;
        end
        HPB_STROBE:
        begin
          if (cnt_r == `HPB_ZERO_CNT)
          begin
            cnt_r   <= `HPB_CNT_W'(`HPB_TURN_CYC - 1);
            state_r <= HPB_TURN;
          end
          else
            cnt_r <= cnt_r - 1'b1;
        end
        HPB_TURN:
        begin
          // bus released, gap lets device drivers turn off
          if (cnt_r == `HPB_ZERO_CNT)
            state_r <= HPB_IDLE;
          else
            cnt_r <= cnt_r - 1'b1;
        end
        default:
          state_r <= HPB_IDLE;
      endcase
    end
  end

  // pin drive; chip select falls one cycle after entry to setup with address stable
  always_ff @(posedge mclk or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
    begin
      chip_sel_n                    <= 1'b1;
      out_drv_en_n                  <= 1'b1;
      write_en_n                    <= 1'b1;
      dedicated_addr_bit2_or_strobe <= 1'b0;
      dedicated_addr_hi             <= 3'b000;
      data_out                      <= `HPB_ZERO32;
      data_oe_n                     <= `HPB_ONES32;
    end
    else
    begin
      case (state_r)
        HPB_IDLE:
        begin
          chip_sel_n   <= 1'b1;
          out_drv_en_n <= 1'b1;
          write_en_n   <= 1'b1;
          data_oe_n    <= `HPB_ONES32;
          if (req_valid && mux_mode)
          begin
            // address on shared lines, strobe high
            dedicated_addr_bit2_or_strobe <= 1'b1;
            data_out  <= {req_addr[31:2], 2'b00};
            data_oe_n <= `HPB_ZERO32;
          end
          else if (req_valid)
          begin
            // dedicated pins set up before chip select
            dedicated_addr_bit2_or_strobe <= req_addr[`HPB_ADDR_LSB];
            dedicated_addr_hi <= req_addr[`HPB_ADDR_MSB:`HPB_BIT3];
            write_en_n <= ~req_write;
          end
        end
        HPB_ALE:
        begin
          if (cnt_r == `HPB_ZERO_CNT)
          begin
            // strobe falls: address latched by device
            dedicated_addr_bit2_or_strobe <= 1'b0;
            dedicated_addr_hi <= 3'b000;
            write_en_n <= ~wr_r;
            data_oe_n  <= wr_r ? `HPB_ZERO32 : `HPB_ONES32;
            data_out   <= wdata_r;
          end
        end
        HPB_SETUP:
        begin
          chip_sel_n <= 1'b0;
          if (wr_r)
          begin
            data_out  <= wdata_r;
            data_oe_n <= `HPB_ZERO32;
          end
          else
            data_oe_n <= `HPB_ONES32;
        end
        HPB_STROBE:
        begin
          // read: enable only while our drivers are off
          out_drv_en_n <= wr_r;
          if (cnt_r == `HPB_ZERO_CNT)
          begin
            chip_sel_n   <= 1'b1;
            out_drv_en_n <= 1'b1;
          end
        end
        HPB_TURN:
        begin
          data_oe_n  <= `HPB_ONES32;
          write_en_n <= 1'b1;
        end
        default:
          data_oe_n <= `HPB_ONES32;
      endcase
    end
  end

  // handshake and read capture at end of strobe
  always_ff @(posedge mclk or negedge rst_s2_r)
  begin
    if (!rst_s2_r)
    begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= `HPB_ZERO32;
    end
    else
    begin
      req_ready <= (state_r == HPB_IDLE) && !req_valid
                   || (state_r == HPB_TURN) && (cnt_r == `HPB_ZERO_CNT);
      rsp_valid <= 1'b0;
      if (state_r == HPB_STROBE && cnt_r == `HPB_ZERO_CNT)
      begin
        rsp_valid <= 1'b1;
        if (!wr_r)
          rsp_rdata <= data_in;
      end
    end
  end

endmodule

// File: hpb_checker.sv
// Purpose: pin protocol checks for the host bus master
// Assumes: sees only hpb_host ports
// Notes:   bound below
`timescale 1ns/1ps
module hpb_checker (
  // clock, reset, strap
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        mux_mode,
  // pins and response
  input wire logic        chip_sel_n,
  input wire logic        out_drv_en_n,
  input wire logic        write_en_n,
  input wire logic        dedicated_addr_bit2_or_strobe,
  input wire logic [5:3]  dedicated_addr_hi,
  input wire logic [31:0] data_oe_n,
  input wire logic        rsp_valid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // device drive only on reads, host off the bus meanwhile
  property p_rd_we; !out_drv_en_n |-> write_en_n; endproperty
  a_rd_we: assert property (p_rd_we) else $error("enable on write");
  property p_rd_oe; !out_drv_en_n |-> &data_oe_n; endproperty
  a_rd_oe: assert property (p_rd_oe) else $error("contention");
  property p_wr_oe;
    $fell(chip_sel_n) && !write_en_n |-> data_oe_n == 32'h0000_0000;
  endproperty
  a_wr_oe: assert property (p_wr_oe) else $error("write undriven");
  // fixed strobe length keeps the device timing met
  property p_cs; $fell(chip_sel_n) |-> !chip_sel_n[*8] ##1 chip_sel_n;
  endproperty
  a_cs: assert property (p_cs) else $error("select length");
  property p_rsp;
    rsp_valid |-> chip_sel_n && $past(chip_sel_n, 2) == 1'b0 ##1 !rsp_valid;
  endproperty
  a_rsp: assert property (p_rsp) else $error("response timing");
  property p_ad_st; !mux_mode && $fell(chip_sel_n) |->
    $stable(dedicated_addr_hi) && $stable(dedicated_addr_bit2_or_strobe);
  endproperty
  a_ad_st: assert property (p_ad_st) else $error("address moves");
  property p_mx_hi;
    mux_mode && $fell(chip_sel_n) |-> dedicated_addr_hi == 3'h0;
  endproperty
  a_mx_hi: assert property (p_mx_hi) else $error("bit4 pin used");
  property p_ale; mux_mode && dedicated_addr_bit2_or_strobe |->
    chip_sel_n && data_oe_n == 32'h0000_0000; endproperty
  a_ale: assert property (p_ale) else $error("address phase");
  c_rd: cover property (!mux_mode && !out_drv_en_n);
  c_ale: cover property (mux_mode && dedicated_addr_bit2_or_strobe);
  c_mwr: cover property (mux_mode && !write_en_n && !chip_sel_n);
endmodule
bind hpb_host hpb_checker u_chk (.mclk, .rstn, .mux_mode, .chip_sel_n,
  .out_drv_en_n, .write_en_n, .dedicated_addr_bit2_or_strobe,
  .dedicated_addr_hi, .data_oe_n, .rsp_valid);

// File: hpb_dev_model.sv
// Purpose: behavioural device side of the parallel host port
// Assumes: pins change just after mclk edges
// Notes:   16 words, index from address bits 5:2
`timescale 1ns/1ps
module hpb_dev_model (
  // clock and strap
  input wire logic        mclk,
  input wire logic        mux_mode,
  // host pins
  input wire logic        chip_sel_n,
  input wire logic        out_drv_en_n,
  input wire logic        write_en_n,
  input wire logic        dedicated_addr_bit2_or_strobe,
  input wire logic [5:3]  dedicated_addr_hi,
  input wire logic [31:0] data_out,
  input wire logic [31:0] data_oe_n,
  output logic     [31:0] data_in
);
  logic [31:0] mem [16];
  logic [31:0] last_q = 32'h0000_0000;
  logic [3:0]  wa;
  logic        cs_q;
  wire  [31:0] bus = (data_out & ~data_oe_n) | (data_in & data_oe_n);
  // index taken at select fall (nonmux); bit4 pin ignored when muxed
  wire  [3:0]  ia = (!mux_mode && cs_q && !chip_sel_n) ?
    {dedicated_addr_hi, dedicated_addr_bit2_or_strobe} : wa;
  // latch strobe takes address off the shared lines
  always @(posedge mclk)
  begin
    cs_q <= chip_sel_n;
    last_q <= data_in;
    wa <= (mux_mode && dedicated_addr_bit2_or_strobe) ? bus[5:2] : ia;
    if (!chip_sel_n && !write_en_n) mem[ia] <= bus;
  end
  // released bus shows no stale value
  assign data_in = out_drv_en_n ? ~last_q : mem[wa];
endmodule

// File: hpb_host_tb.sv
// Purpose: self-checking bench for hpb_host against the device model
// Assumes: 4 ns mclk
// Notes:   table rows, then reset cases
`timescale 1ns/1ps
module hpb_host_tb;
  typedef struct packed {logic m; logic w; logic [31:0] a; logic [31:0] d;}
    hpb_row_t;
  logic        mclk, rstn = 0, mux_mode = 0, req_valid = 0, req_write = 0;
  logic [31:0] req_addr = '0, req_wdata = '0, rsp_rdata, data_out, data_oe_n;
  logic [31:0] data_in, q;
  logic        req_ready, rsp_valid, chip_sel_n, out_drv_en_n, write_en_n;
  logic        dedicated_addr_bit2_or_strobe;
  logic [5:3]  dedicated_addr_hi;
  int          fail_count = 0, cmp_count = 0, n;
  wire  [31:0] pins = 32'({chip_sel_n, out_drv_en_n, write_en_n,
                           rsp_valid, &data_oe_n});
  // nonmux writes first; later reads cross modes, first two reads use odd byte bits
  hpb_row_t rows [8] = '{
    '{1'b0, 1'b1, 32'h0000_0004, 32'h1234_5678},
    '{1'b0, 1'b1, 32'h0000_0028, 32'hA5A5_5A5A},
    '{1'b0, 1'b0, 32'h0000_0007, 32'h1234_5678},
    '{1'b0, 1'b0, 32'h0000_002B, 32'hA5A5_5A5A},
    '{1'b1, 1'b1, 32'h0000_0038, 32'h0F0F_F0F0},
    '{1'b1, 1'b0, 32'h0000_0028, 32'hA5A5_5A5A},
    '{1'b0, 1'b0, 32'h0000_0038, 32'h0F0F_F0F0},
    '{1'b1, 1'b0, 32'h0000_0004, 32'h1234_5678}};
  hpb_host DUT (.mclk, .rstn, .mux_mode, .req_valid, .req_write, .req_addr,
    .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .chip_sel_n,
    .out_drv_en_n, .write_en_n, .dedicated_addr_bit2_or_strobe,
    .dedicated_addr_hi, .data_out, .data_oe_n, .data_in);
  hpb_dev_model u_dev (.mclk, .mux_mode, .chip_sel_n, .out_drv_en_n,
    .write_en_n, .dedicated_addr_bit2_or_strobe, .dedicated_addr_hi,
    .data_out, .data_oe_n, .data_in);
  initial
  begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  task automatic wrap_up();
    if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // ready is a hint only, so wait for it before each request
  task automatic start(input hpb_row_t r);
    n = 0;
    while (req_ready !== 1'b1 && n < 50)
    begin
      @(posedge mclk);
      #1 n++;
    end
    if (req_ready !== 1'b1)
    begin
      chk(32'h0000_0000, 32'h0000_0001);
      wrap_up();
    end
    @(posedge mclk);
    {mux_mode, req_write, req_addr, req_wdata} <= r;
    req_valid <= 1'b1;
    @(posedge mclk);
    req_valid <= 1'b0;
  endtask
  // one full access; n ends as cycles from take to response
  task automatic acc(input hpb_row_t r);
    start(r);
    n = 0;
    do
    begin
      @(posedge mclk);
      #1 n++;
    end while (rsp_valid !== 1'b1 && n < 40);
    q = rsp_rdata;
    if (n >= 40)
    begin
      chk(32'h0000_0000, 32'h0000_0001);
      wrap_up();
    end
  endtask
  initial
  begin
    repeat (12) @(posedge mclk);
    #1 chk(pins, 32'h0000_001D);
    @(posedge mclk) rstn <= 1'b1;
    foreach (rows[i])
    begin
      acc(rows[i]);
      chk(32'(n), 32'(9 + 2 * rows[i].m));
      if (!rows[i].w) chk(q, rows[i].d);
    end
    // reset lands mid-read: selects, enables and data drivers must let go at once
    start(rows[6]);
    repeat (5) @(posedge mclk);
    #1 chk(pins, 32'h0000_0005);
    chk(32'(req_ready), 32'h0000_0000);
    @(posedge mclk) rstn <= 1'b0;
    #1 chk(pins, 32'h0000_001D);
    @(posedge mclk) rstn <= 1'b1;
    acc(rows[2]);
    chk(32'(n), 32'h0000_0009);
    chk(q, rows[2].d);
    wrap_up();
  end
endmodule
